//--- logic/ibf_bus_state_flags.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Contract
// - start condition sets start seen
// - start seen cleared: stop, next byte, exit, disable
// - start seen means address transfer period
// - stop condition sets stop seen
// - stop seen cleared: next address byte, disable
// - flag register 8 bits, resets 00h
// - busy and start failed bits ignore writes
// - failed start clears request, sets failed flag (the code does so only while reservation disable is set)
// - busy initial value follows initial start enable
// - busy set on start or enable without it
// - busy cleared by stop, disable, reset
// - start permitted after stop or initial enable
// - initial start enable cleared by start condition
// - reservation disable changed only by software
////////////////////////////////////////////////////////////////////////////
module ibf_bus_state_flags
   import ibf_pkg::*;
(
   // clocks and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_scl_clk,
   // bus pins
   input wire logic i_serial_clock_pin,
   input wire logic i_serial_data_pin,
   // control from control register 0
   input wire logic i_block_enable,
   input wire logic i_exit_comm_cmd,
   input wire logic i_start_request,
   input wire logic i_start_attempt_failed,
   // flag register access
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [19:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // status
   output ibf_pkg::ibf_flags_s o_flags,
   output ibf_pkg::ibf_status_s o_status,
   output logic o_start_request,
   output logic o_start_permitted
);
   import ibf_pkg::*;

   logic scl_tgl_r;
   logic [2:0] tgl_sync_r;
   logic [2:0] scl_sync_r;
   logic [2:0] sda_sync_r;
   logic scl_rise, start_det, stop_det;
   logic en_q_r;
   logic en_rise;
   logic [3:0] rise_cnt_r;
   logic [3:0] rise_cnt_nxt;
   logic start_seen_r, stop_seen_r, busy_r, failed_r;
   logic ise_r, rsv_r, req_r, permit_r;
   logic flag_wr;
   ibf_flags_s flags_nxt;

   ////////////////////////////////////////////////////////////////////////
   // link domain: one toggle per serial clock rise, crossed as an event
   always_ff @(posedge i_scl_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_tgl_r <= 1'b0;
      end else begin
         scl_tgl_r <= ~scl_tgl_r;
      end
   end

   // pins pass two flops; stage three only feeds edge detection
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tgl_sync_r <= 3'h0;
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
      end else begin
         tgl_sync_r <= {tgl_sync_r[1:0], scl_tgl_r};
         scl_sync_r <= {scl_sync_r[1:0], i_serial_clock_pin};
         sda_sync_r <= {sda_sync_r[1:0], i_serial_data_pin};
      end
   end

   assign scl_rise = tgl_sync_r[2] ^ tgl_sync_r[1];
   // data moving while the clock stays high marks start or stop
   assign start_det = i_block_enable && scl_sync_r[1] && scl_sync_r[2] &&
                      sda_sync_r[2] && !sda_sync_r[1];
   assign stop_det = i_block_enable && scl_sync_r[1] && scl_sync_r[2] &&
                     !sda_sync_r[2] && sda_sync_r[1];

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         en_q_r <= 1'b0;
      end else begin
         en_q_r <= i_block_enable;
      end
   end
   assign en_rise = i_block_enable && !en_q_r;

   // serial clock rises since the last start, saturating
   always_comb begin
      rise_cnt_nxt = rise_cnt_r;
      if (start_det) begin
         rise_cnt_nxt = 4'h0;
      end else if (scl_rise && rise_cnt_r != RISE_NEXT_FIRST) begin
         rise_cnt_nxt = rise_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rise_cnt_r <= RISE_NEXT_FIRST;
      end else begin
         rise_cnt_r <= rise_cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start seen marks the address transfer period
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         start_seen_r <= 1'b0;
      end else if (!i_block_enable) begin
         start_seen_r <= 1'b0;
      end else if (start_det) begin
         start_seen_r <= 1'b1;
      end else if (stop_det || i_exit_comm_cmd) begin
         start_seen_r <= 1'b0;
      end else if (scl_rise && rise_cnt_nxt == RISE_NEXT_FIRST &&
                   rise_cnt_r != RISE_NEXT_FIRST) begin
         start_seen_r <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         stop_seen_r <= 1'b0;
      end else if (!i_block_enable) begin
         stop_seen_r <= 1'b0;
      end else if (stop_det) begin
         stop_seen_r <= 1'b1;
      end else if (scl_rise && rise_cnt_nxt == RISE_ADDR_FIRST) begin
         stop_seen_r <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_r <= 1'b0;
      end else if (!i_block_enable) begin
         busy_r <= 1'b0;
      end else if (start_det || (en_rise && !ise_r)) begin
         busy_r <= 1'b1;
      end else if (stop_det) begin
         busy_r <= 1'b0;
      end
   end

   // start may be issued once a stop was seen, or at once with ise
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         permit_r <= 1'b0;
      end else if (!i_block_enable) begin
         permit_r <= 1'b0;
      end else if ((en_rise && ise_r) || stop_det) begin
         permit_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software bits; writes only land while the block is stopped
   assign flag_wr = i_reg_wr && i_reg_addr == FLAG_REG_ADDR &&
                    !i_block_enable;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ise_r <= FLAG_REG_RESET[BIT_INIT_START_EN];
      end else if (start_det) begin
         ise_r <= 1'b0;
      end else if (flag_wr) begin
         ise_r <= i_reg_wdata[BIT_INIT_START_EN];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rsv_r <= FLAG_REG_RESET[BIT_RSV_DISABLE];
      end else if (flag_wr) begin
         rsv_r <= i_reg_wdata[BIT_RSV_DISABLE];
      end
   end

   // start request: a failure with reservation off drops it
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         req_r <= 1'b0;
      end else if (!i_block_enable) begin
         req_r <= 1'b0;
      end else if (i_start_attempt_failed && rsv_r) begin
         req_r <= 1'b0;
      end else if (i_start_request) begin
         req_r <= 1'b1;
      end
   end

   // set beats the clearing new request in the same cycle
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         failed_r <= 1'b0;
      end else if (!i_block_enable) begin
         failed_r <= 1'b0;
      end else if (i_start_attempt_failed && rsv_r && req_r) begin
         failed_r <= 1'b1;
      end else if (i_start_request) begin
         failed_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bits 6 and 7 have no write path at all
   always_comb begin
      flags_nxt = FLAG_REG_RESET;
      flags_nxt.start_failed_flag = failed_r;
      flags_nxt.bus_busy_flag = busy_r;
      flags_nxt.initial_start_enable = ise_r;
      flags_nxt.reservation_disable = rsv_r;
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_flags <= FLAG_REG_RESET;
         o_reg_rdata <= 8'h00;
         o_status <= '0;
         o_start_request <= 1'b0;
         o_start_permitted <= 1'b0;
      end else begin
         o_flags <= flags_nxt;
         o_reg_rdata <= (i_reg_rd && i_reg_addr == FLAG_REG_ADDR) ?
                        flags_nxt : 8'h00;
         o_status <= {start_seen_r, stop_seen_r};
         o_start_request <= req_r;
         o_start_permitted <= permit_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   a_start_sets_seen: assert property (start_det |=> start_seen_r)
      else $error("start not recorded");
   a_stop_clears_seen: assert property
      (stop_det && !start_det |=> !start_seen_r)
      else $error("start seen kept after stop");
   a_stop_sets_seen: assert property (stop_det |=> stop_seen_r)
      else $error("stop not recorded");
   a_disable_clears_all: assert property
      (!i_block_enable |=> !start_seen_r && !stop_seen_r && !busy_r &&
       !failed_r)
      else $error("flags kept while disabled");
   a_busy_on_enable: assert property
      (en_rise && !ise_r |=> busy_r)
      else $error("busy not set at enable");
   a_busy_free_enable: assert property
      (en_rise && ise_r && !start_det |=> !busy_r)
      else $error("busy set despite initial start enable");
   a_fail_sets_flag: assert property
      (i_start_attempt_failed && rsv_r && req_r && i_block_enable |=>
       failed_r && !req_r)
      else $error("failed start not flagged");
   a_ise_clear_start: assert property (start_det |=> !ise_r)
      else $error("initial start enable kept after start");
   a_ro_bits_ignore: assert property
      (i_reg_wr && !i_reg_addr[0] |=> o_flags[5:2] == 4'h0)
      else $error("reserved bits nonzero");
   a_rsv_stable_run: assert property
      (i_block_enable |=> $stable(rsv_r))
      else $error("reservation bit changed while running");
   a_flag_output_lag: assert property
      (##1 o_flags.bus_busy_flag == $past(busy_r))
      else $error("busy output lags wrong");
   a_next_byte_clear: assert property
      (start_seen_r && scl_rise && rise_cnt_r == 4'h9 && !start_det &&
       i_block_enable |=> !start_seen_r)
      else $error("start seen kept into next byte");
   a_addr_clears_stop: assert property
      (stop_seen_r && scl_rise && rise_cnt_r == 4'h0 && !stop_det &&
       !start_det |=> !stop_seen_r)
      else $error("stop seen kept into address byte");
   a_permit_after_stop: assert property
      (stop_det |=> permit_r ##1 o_start_permitted)
      else $error("start not permitted after stop");

   c_start_stop: cover property (start_det ##[1:1000] stop_det);
   c_fail_flag: cover property (failed_r);
   c_next_byte: cover property (start_seen_r ##1 !start_seen_r && busy_r);
   c_enable_busy: cover property (en_rise && !ise_r);
   c_exit_cmd: cover property (i_exit_comm_cmd && start_seen_r);

   // flag set and clear paths, output register stages and read data not covered above
   a_start_sets_busy: assert property (start_det |=> busy_r)
      else $error("busy not set at start");
   a_stop_clears_busy: assert property
      (stop_det && !start_det |=> !busy_r)
      else $error("busy kept after stop");
   a_new_req_clear: assert property
      (i_start_request && i_block_enable &&
       !(i_start_attempt_failed && rsv_r && req_r) |=> !failed_r)
      else $error("failed flag kept after new request");
   a_permit_disable: assert property
      (!i_block_enable |=> !permit_r)
      else $error("start permitted while disabled");
   a_no_early_permit: assert property
      (en_rise && !ise_r && !stop_det |=> !permit_r)
      else $error("start permitted before any stop");
   a_ise_hold_run: assert property
      (i_block_enable && !start_det |=> $stable(ise_r))
      else $error("initial start enable changed while running");
   a_status_lag: assert property
      (##1 o_status.start_seen == $past(start_seen_r))
      else $error("start seen output lags wrong");
   a_zero_bits: assert property (o_flags.zero == 4'h0)
      else $error("unused flag bits nonzero");
   a_rdata_idle: assert property
      (!i_reg_rd |=> o_reg_rdata == 8'h00)
      else $error("read data without a read");
   a_rdata_flags: assert property
      (i_reg_rd && i_reg_addr == FLAG_REG_ADDR |=> o_reg_rdata == o_flags)
      else $error("read data differs from flags");
   a_req_out_lag: assert property
      (##1 o_start_request == $past(req_r))
      else $error("start request output lags wrong");
   a_exit_clears_seen: assert property
      (i_exit_comm_cmd && i_block_enable && !start_det |=>
       !start_seen_r)
      else $error("start seen kept after exit");
   a_start_keeps_stop: assert property
      (start_det && stop_seen_r |=> stop_seen_r)
      else $error("stop seen cleared by start itself");
   a_fail_out_lag: assert property
      (##1 o_flags.start_failed_flag == $past(failed_r))
      else $error("failed flag output lags wrong");
endmodule
`default_nettype wire

//--- logic/ibf_pkg.sv
package ibf_pkg;
   // register map
   localparam logic [19:0] FLAG_REG_ADDR = 20'hfff52;
   localparam logic [7:0] FLAG_REG_RESET = 8'h00;
   // field positions of the flag register
   localparam int BIT_RSV_DISABLE = 0;
   localparam int BIT_INIT_START_EN = 1;
   localparam int BIT_BUS_BUSY = 6;
   localparam int BIT_START_FAILED = 7;
   // serial clock rises counted from a start condition
   localparam logic [3:0] RISE_ADDR_FIRST = 4'h1;
   localparam logic [3:0] RISE_NEXT_FIRST = 4'ha;

   typedef struct packed {
      logic start_failed_flag;
      logic bus_busy_flag;
      logic [3:0] zero;
      logic initial_start_enable;
      logic reservation_disable;
   } ibf_flags_s;

   typedef struct packed {
      logic start_seen;
      logic stop_seen;
   } ibf_status_s;
endpackage

//--- testbench/ibf_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ibf_bus_peer (
   // bus lines, idle high as with pull-ups
   output logic o_scl,
   output logic o_sda
);
   logic tick;
   initial begin
      tick = 1'b0;
      o_scl = 1'b1;
      o_sda = 1'b1;
      #3;
      forever #6 tick = ~tick;
   end
   // one bus phase is 8 link ticks, so the slower system side sees it
   task automatic hold();
      repeat (8) @(posedge tick);
   endtask
   task automatic start_cond();
      o_sda = 1'b1;
      hold();
      o_scl = 1'b1;
      hold();
      o_sda = 1'b0;
      hold();
      o_scl = 1'b0;
      hold();
   endtask
   // data only moves while the clock is low, never a false start or stop
   task automatic clocks(input int n);
      repeat (n) begin
         o_sda = 1'($urandom);
         hold();
         o_scl = 1'b1;
         hold();
         o_scl = 1'b0;
         hold();
      end
   endtask
   task automatic stop_cond();
      o_sda = 1'b0;
      hold();
      o_scl = 1'b1;
      hold();
      o_sda = 1'b1;
      hold();
   endtask
endmodule
`default_nettype wire

//--- testbench/tb_ibf_bus_state_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ibf_bus_state_flags;
   import ibf_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic en = 1'b0;
   logic [2:0] pls = 3'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_q = 1'b0;
   logic [19:0] addr = FLAG_REG_ADDR;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [7:0] r;
   ibf_flags_s flags;
   ibf_status_s status;
   logic req;
   logic perm;
   wire scl;
   wire sda;
   logic [12:0] exp_q[$];
   logic [12:0] e;
   int fails = 0;
   int tests_run = 0;
   int cyc = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   ibf_bus_peer u_ibf_bus_peer (.o_scl(scl), .o_sda(sda));
   ibf_bus_state_flags u_ibf_bus_state_flags (
      .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_scl_clk(scl),
      .i_serial_clock_pin(scl), .i_serial_data_pin(sda),
      .i_block_enable(en), .i_exit_comm_cmd(pls[2]),
      .i_start_request(pls[1]), .i_start_attempt_failed(pls[0]),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_flags(flags),
      .o_status(status), .o_start_request(req), .o_start_permitted(perm));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [7:0] s,
                        input logic [7:0] x);
      tests_run++;
      if (s !== x) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
      @(negedge i_sys_clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge i_sys_clk);
      wr = 1'b0;
   endtask
   // waits out the two-flop pin sync and the output register stage
   task automatic rd_exp(input logic pc, input logic p, input logic q,
                         input logic [1:0] st, input logic [7:0] d);
      repeat (8) @(negedge i_sys_clk);
      rd = 1'b1;
      addr = FLAG_REG_ADDR;
      exp_q.push_back({pc, p, q, st, d});
      @(negedge i_sys_clk);
      rd = 1'b0;
   endtask
   task automatic pulse(input logic [2:0] v);
      @(negedge i_sys_clk);
      pls = v;
      @(negedge i_sys_clk);
      pls = 3'h0;
   endtask
   task automatic set_en(input logic v);
      @(negedge i_sys_clk);
      en = v;
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge i_sys_clk) begin
      rd_q <= rd;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end
   always @(negedge i_sys_clk) begin
      if (rd_q === 1'b1) begin
         e = exp_q.pop_front();
         check("rdata", rdata, e[7:0]);
         check("flags", flags, e[7:0]);
         check("status", {6'h00, status}, {6'h00, e[9:8]});
         check("start_request", {7'h00, req}, {7'h00, e[10]});
         if (e[12] === 1'b1) begin
            check("permitted", {7'h00, perm}, {7'h00, e[11]});
         end
      end
   end
   initial begin
      void'($urandom(32'h5da0));
      repeat (8) @(negedge i_sys_clk);
      i_rstn = 1'b1;
      rd_exp(0, 0, 0, 2'b00, FLAG_REG_RESET);
      repeat (4) begin
         r = 8'($urandom);
         wr_reg(FLAG_REG_ADDR + 20'h1, 8'hff);
         wr_reg(FLAG_REG_ADDR, r);
         rd_exp(0, 0, 0, 2'b00, r & 8'h03);
      end
      wr_reg(FLAG_REG_ADDR, 8'h01);
      set_en(1'b1);
      rd_exp(1, 0, 0, 2'b00, 8'h41);
      wr_reg(FLAG_REG_ADDR, 8'h02);
      rd_exp(1, 0, 0, 2'b00, 8'h41);
      u_ibf_bus_peer.start_cond();
      rd_exp(1, 0, 0, 2'b10, 8'h41);
      u_ibf_bus_peer.clocks(9);
      rd_exp(1, 0, 0, 2'b10, 8'h41);
      u_ibf_bus_peer.clocks(1);
      rd_exp(1, 0, 0, 2'b00, 8'h41);
      u_ibf_bus_peer.stop_cond();
      rd_exp(1, 1, 0, 2'b01, 8'h01);
      pulse(3'b010);
      rd_exp(1, 1, 1, 2'b01, 8'h01);
      pulse(3'b001);
      rd_exp(1, 1, 0, 2'b01, 8'h81);
      pulse(3'b010);
      rd_exp(1, 1, 1, 2'b01, 8'h01);
      pulse(3'b001);
      u_ibf_bus_peer.start_cond();
      rd_exp(0, 0, 0, 2'b11, 8'hc1);
      u_ibf_bus_peer.clocks(1);
      rd_exp(0, 0, 0, 2'b10, 8'hc1);
      pulse(3'b100);
      rd_exp(0, 0, 0, 2'b00, 8'hc1);
      set_en(1'b0);
      rd_exp(0, 0, 0, 2'b00, 8'h01);
      wr_reg(FLAG_REG_ADDR, 8'h02);
      set_en(1'b1);
      rd_exp(1, 1, 0, 2'b00, 8'h02);
      u_ibf_bus_peer.start_cond();
      rd_exp(0, 0, 0, 2'b10, 8'h40);
      final_report();
   end
endmodule
`default_nettype wire
